/* File: rtl/port_a_b_io.sv */
// Port A/B pin logic, R/W pin and input-only pins with a Wishbone slave
//
// Behaviour
// - Expanded/test: R/W pin high during reads
// - Single chip: R/W pin held low
// - G7, G6, port E only inputs
// - Port B general I/O only single/bootstrap
// - Reset-input pins stay high impedance
// - Data registers reflect mode-latched functional state
// - Port A pins shared with timer
// - Port A read returns pin levels
// - Port A write loads latch; drive if output
// - Compare-owned pin ignores data writes
// - Port A comes up as inputs
// - Direction bit rules pin without alternate function
// - Port B: I/O or address [15:8]
// - Port B read returns pin levels
// - Port B driven if output, single/bootstrap
// - Port B pull-ups switched by software
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module port_a_b_io (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [port_ab_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [port_ab_pkg::DAT_W-1:0]  wb_dat_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic                           wb_we_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  output logic      [port_ab_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic [1:0]                     modePins,
  input  wire logic                           busCycle,
  input  wire logic                           busWrite,
  input  wire logic [port_ab_pkg::PORT_W-1:0] extAddrHigh,
  input  wire logic [port_ab_pkg::PORT_W-1:0] timerPinLevel,
  input  wire logic [port_ab_pkg::PORT_W-1:0] portAIn,
  output logic      [port_ab_pkg::PORT_W-1:0] portAOut,
  output logic      [port_ab_pkg::PORT_W-1:0] portAOe,
  input  wire logic [port_ab_pkg::PORT_W-1:0] portBIn,
  output logic      [port_ab_pkg::PORT_W-1:0] portBOut,
  output logic      [port_ab_pkg::PORT_W-1:0] portBOe,
  output logic      [port_ab_pkg::PORT_W-1:0] portBPullEn,
  input  wire logic [port_ab_pkg::PORT_W-1:0] portEIn,
  input  wire logic [1:0]                     portGHighIn,
  output logic      [9:0]                     inputOnlyLevel,
  output logic                                pulseAccumInput,
  output logic                                captureFourIn,
  output logic      [2:0]                     captureLowIn,
  output logic                                rwPin
);
  import port_ab_pkg::*;

  typedef struct packed {
    logic              ack;
    logic [DAT_W-1:0]  rdata;
    logic [PORT_W-1:0] aLatch;
    logic [PORT_W-1:0] aDir;
    logic [PORT_W-1:0] bLatch;
    logic [PORT_W-1:0] bDir;
    logic [PORT_W-1:0] pullAssign;
    logic [PORT_W-1:0] timerAssign;
    logic [PORT_W-1:0] pullEn;
    mode_t             mode;
    phase_t            phase;
    logic              rw;
  } state_t;

  typedef enum logic [3:0] {
    REG_A_DATA  = 4'h0,
    REG_A_DIR   = 4'h1,
    REG_B_DATA  = 4'h2,
    REG_B_DIR   = 4'h3,
    REG_PULLUP  = 4'h4,
    REG_TIMER   = 4'h5,
    REG_IN_ONLY = 4'h6,
    REG_STATUS  = 4'h7,
    REG_NONE    = 4'hF
  } reg_t;

  state_t            s;
  state_t            next_s;
  logic [SYNC_W-1:0] pinsRaw;
  logic [SYNC_W-1:0] pinsSync;
  logic [PORT_W-1:0] aPins;
  logic [PORT_W-1:0] bPins;
  logic [PORT_W-1:0] ePins;
  logic [1:0]        gPins;
  logic [1:0]        modeSync;
  logic              wbReq;
  logic              running;
  logic              generalMode;
  logic              busMode;
  reg_t              hit;
  logic [PORT_W-1:0] timerOwned;

  port_ctrl_if #(.W(PORT_W)) aIf ();
  port_ctrl_if #(.W(PORT_W)) bIf ();

  // Address decode shared by reads and writes
  function automatic reg_t decode(input logic [ADR_W-1:0] adr);
    reg_t r;
    r = REG_NONE;
    unique case (adr)
      ADR_A_DATA:  r = REG_A_DATA;
      ADR_A_DIR:   r = REG_A_DIR;
      ADR_B_DATA:  r = REG_B_DATA;
      ADR_B_DIR:   r = REG_B_DIR;
      ADR_PULLUP:  r = REG_PULLUP;
      ADR_TIMER:   r = REG_TIMER;
      ADR_IN_ONLY: r = REG_IN_ONLY;
      ADR_STATUS:  r = REG_STATUS;
      default:     r = REG_NONE;
    endcase
    return r;
  endfunction

  // Byte lane zero write of an 8-bit register
  function automatic logic [PORT_W-1:0] laneWrite(
    input logic [PORT_W-1:0] old,
    input logic [DAT_W-1:0]  dat,
    input logic              lane
  );
    logic [PORT_W-1:0] v;
    v = lane ? dat[PORT_W-1:0] : old;
    return v;
  endfunction

  // Zero-extend an 8-bit value onto the data bus
  function automatic logic [DAT_W-1:0] widen(input logic [PORT_W-1:0] v);
    logic [DAT_W-1:0] w;
    w = '0;
    w[PORT_W-1:0] = v;
    return w;
  endfunction

  // Package constants must fit the bus, the lanes and the fields
  initial begin
    if (PORT_W > DAT_W) begin
      $error("port width exceeds the data bus");
    end
    if (SYNC_W != SYNC_MODE + 2) begin
      $error("synchroniser lanes do not fill the synchroniser");
    end
    if (SYNC_A + PORT_W > SYNC_B || SYNC_B + PORT_W > SYNC_E) begin
      $error("port synchroniser lanes overlap");
    end
    if (SYNC_E + PORT_W > SYNC_G || SYNC_G + 2 > SYNC_MODE) begin
      $error("input-only synchroniser lanes overlap");
    end
    if (IN_G_LSB < PORT_W || IN_G_LSB + 2 > DAT_W) begin
      $error("input-only field misplaced");
    end
    if (STAT_RUN < 2 || STAT_RUN >= DAT_W) begin
      $error("status run bit misplaced");
    end
    if (PAI_BIT >= PORT_W || CAP4_BIT >= PORT_W || PULL_B_BIT >= PORT_W) begin
      $error("pin index outside the port");
    end
  end

  // Every pin and mode input crosses two flip-flops
  assign pinsRaw = {modePins, portGHighIn, portEIn, portBIn, portAIn};

  pin_sync #(.W(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .async   (pinsRaw),
    .sync    (pinsSync)
  );

  assign aPins    = pinsSync[SYNC_A +: PORT_W];
  assign bPins    = pinsSync[SYNC_B +: PORT_W];
  assign ePins    = pinsSync[SYNC_E +: PORT_W];
  assign gPins    = pinsSync[SYNC_G +: 2];
  assign modeSync = pinsSync[SYNC_MODE +: 2];

  assign running     = (s.phase == PH_RUN);
  assign generalMode = running && (s.mode == MODE_SINGLE || s.mode == MODE_BOOT);
  assign busMode     = running && (s.mode == MODE_EXPANDED || s.mode == MODE_TEST);
  assign wbReq       = wb_cyc_i & wb_stb_i & ~s.ack;
  assign hit         = decode(wb_adr_i);

  // Port A: timer sharing and direction control
  assign aIf.latch  = s.aLatch;
  assign aIf.dir    = s.aDir;
  // Compare outputs take pins only once running
  assign timerOwned = running ? (s.timerAssign & TIMER_OUT_OK) : '0;
  assign aIf.altEn  = timerOwned;
  assign aIf.altVal = timerPinLevel;
  assign aIf.busVal = '0;
  assign aIf.genEn  = running;
  assign aIf.busEn  = 1'b0;

  // Port B: general I/O or high address byte
  assign bIf.latch  = s.bLatch;
  assign bIf.dir    = s.bDir;
  assign bIf.altEn  = '0;
  assign bIf.altVal = '0;
  assign bIf.busVal = extAddrHigh;
  assign bIf.genEn  = generalMode;
  assign bIf.busEn  = busMode;

  port_pin_drive #(.W(PORT_W)) u_drive_a (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pc      (aIf.drive)
  );

  port_pin_drive #(.W(PORT_W)) u_drive_b (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pc      (bIf.drive)
  );

  always_comb begin
    next_s = s;

    // Mode capture once the synchronised pins have settled
    unique case (s.phase)
      PH_SETTLE: begin
        next_s.phase = PH_WAIT;
      end
      PH_WAIT: begin
        next_s.phase = PH_CAPTURE;
      end
      PH_CAPTURE: begin
        next_s.mode  = mode_t'(modeSync);
        next_s.phase = PH_RUN;
      end
      PH_RUN: begin
        next_s.phase = PH_RUN;
      end
    endcase

    // Bus write
    next_s.ack = wbReq;
    if (wbReq && wb_we_i) begin
      unique case (hit)
        REG_A_DATA: begin
          next_s.aLatch = laneWrite(s.aLatch, wb_dat_i, wb_sel_i[0]);
        end
        REG_A_DIR: begin
          next_s.aDir = laneWrite(s.aDir, wb_dat_i, wb_sel_i[0]);
        end
        REG_B_DATA: begin
          next_s.bLatch = laneWrite(s.bLatch, wb_dat_i, wb_sel_i[0]);
        end
        REG_B_DIR: begin
          next_s.bDir = laneWrite(s.bDir, wb_dat_i, wb_sel_i[0]);
        end
        REG_PULLUP: begin
          next_s.pullAssign = laneWrite(s.pullAssign, wb_dat_i, wb_sel_i[0]);
        end
        REG_TIMER: begin
          next_s.timerAssign = laneWrite(s.timerAssign, wb_dat_i, wb_sel_i[0]);
        end
        REG_IN_ONLY, REG_STATUS, REG_NONE: begin
          next_s.ack = wbReq;
        end
      endcase
    end

    // Bus read, zero outside a cycle and at unmapped addresses
    next_s.rdata = '0;
    if (wbReq && !wb_we_i) begin
      unique case (hit)
        REG_A_DATA: begin
          next_s.rdata = widen(aPins);
        end
        REG_A_DIR: begin
          next_s.rdata = widen(s.aDir);
        end
        REG_B_DATA: begin
          next_s.rdata = widen(bPins);
        end
        REG_B_DIR: begin
          next_s.rdata = widen(s.bDir);
        end
        REG_PULLUP: begin
          next_s.rdata = widen(s.pullAssign);
        end
        REG_TIMER: begin
          next_s.rdata = widen(s.timerAssign);
        end
        REG_IN_ONLY: begin
          next_s.rdata = widen(ePins);
          next_s.rdata[IN_G_LSB +: 2] = gPins;
        end
        REG_STATUS: begin
          next_s.rdata[1:0]      = s.mode;
          next_s.rdata[STAT_RUN] = running;
        end
        REG_NONE: begin
          next_s.rdata = '0;
        end
      endcase
    end

    // Pull-ups only where port B is general I/O and not driven
    for (int i = 0; i < PORT_W; i++) begin
      next_s.pullEn[i] = generalMode & s.pullAssign[PULL_B_BIT] & ~s.bDir[i];
    end

    // Read/write direction pin
    if (busMode) begin
      next_s.rw = busCycle ? ~busWrite : 1'b1;
    end else begin
      next_s.rw = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s.ack         <= 1'b0;
      s.rdata       <= '0;
      s.aLatch      <= DATA_RST;
      s.aDir        <= DIR_RST;
      s.bLatch      <= DATA_RST;
      s.bDir        <= DIR_RST;
      s.pullAssign  <= PULLUP_RST;
      s.timerAssign <= TIMER_RST;
      s.pullEn      <= '0;
      s.mode        <= MODE_SINGLE;
      s.phase       <= PH_SETTLE;
      s.rw          <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o        = s.ack;
  assign wb_dat_o        = s.rdata;
  assign portAOut        = aIf.pinOut;
  assign portAOe         = aIf.pinOe;
  assign portBOut        = bIf.pinOut;
  assign portBOe         = bIf.pinOe;
  assign portBPullEn     = s.pullEn;
  assign rwPin           = s.rw;
  assign inputOnlyLevel  = {gPins, ePins};
  assign pulseAccumInput = aPins[PAI_BIT];
  assign captureFourIn   = aPins[CAP4_BIT];
  assign captureLowIn    = aPins[2:0];
endmodule

/* File: rtl/port_ab_pkg.sv */
// Shared constants and types for the port A/B pin logic
package port_ab_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned DAT_W  = 32;

  // Register byte offsets
  localparam logic [7:0] ADR_A_DATA   = 8'h00;
  localparam logic [7:0] ADR_A_DIR    = 8'h04;
  localparam logic [7:0] ADR_B_DATA   = 8'h08;
  localparam logic [7:0] ADR_B_DIR    = 8'h0C;
  localparam logic [7:0] ADR_PULLUP   = 8'h10;
  localparam logic [7:0] ADR_TIMER    = 8'h14;
  localparam logic [7:0] ADR_IN_ONLY  = 8'h18;
  localparam logic [7:0] ADR_STATUS   = 8'h1C;

  // Reset values
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] DIR_RST      = 8'h00;
  localparam logic [7:0] PULLUP_RST   = 8'h00;
  localparam logic [7:0] TIMER_RST    = 8'h00;
  localparam logic [7:0] OE_RST       = 8'hFF;

  // Port A pins that a compare output may take over
  localparam logic [7:0] TIMER_OUT_OK = 8'hF8;

  // Field positions
  localparam int unsigned PULL_B_BIT  = 0;
  localparam int unsigned PAI_BIT     = 7;
  localparam int unsigned CAP4_BIT    = 3;
  localparam int unsigned STAT_RUN    = 2;
  localparam int unsigned IN_G_LSB    = 8;

  // Synchroniser lanes
  localparam int unsigned SYNC_A      = 0;
  localparam int unsigned SYNC_B      = 8;
  localparam int unsigned SYNC_E      = 16;
  localparam int unsigned SYNC_G      = 24;
  localparam int unsigned SYNC_MODE   = 26;
  localparam int unsigned SYNC_W      = 28;

  typedef enum logic [1:0] {
    MODE_BOOT     = 2'h0,
    MODE_TEST     = 2'h1,
    MODE_SINGLE   = 2'h2,
    MODE_EXPANDED = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    PH_SETTLE  = 2'h0,
    PH_WAIT    = 2'h1,
    PH_CAPTURE = 2'h3,
    PH_RUN     = 2'h2
  } phase_t;

endpackage

/* File: rtl/port_ctrl_if.sv */
// Control and pin signals between port logic and one pin driver
`timescale 1ns/1ps
interface port_ctrl_if #(parameter int unsigned W = 8);
  logic [W-1:0] latch;
  logic [W-1:0] dir;
  logic [W-1:0] altEn;
  logic [W-1:0] altVal;
  logic [W-1:0] busVal;
  logic         genEn;
  logic         busEn;
  logic [W-1:0] pinOut;
  logic [W-1:0] pinOe;
  modport ctrl  (output latch, dir, altEn, altVal, busVal, genEn, busEn, input pinOut, pinOe);
  modport drive (input latch, dir, altEn, altVal, busVal, genEn, busEn, output pinOut, pinOe);
endinterface

/* File: rtl/pin_sync.sv */
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] sync
);
  logic [W-1:0] stage;

  initial begin
    if (W < 1) $error("pin_sync width must be at least one");
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage <= '0;
      sync  <= '0;
    end else begin
      stage <= async;
      sync  <= stage;
    end
  end
endmodule

/* File: rtl/port_pin_drive.sv */
// Registered output and enable for one port
`timescale 1ns/1ps
module port_pin_drive #(
  parameter int unsigned W = 8
) (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  port_ctrl_if.drive pc
);
  logic [W-1:0] next_out;
  logic [W-1:0] next_oe;

  initial begin
    if (W < 1 || W > 32) $error("port_pin_drive width out of range");
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pc.busEn) begin
        next_out[i] = pc.busVal[i];
        next_oe[i]  = 1'b0;
      end else if (pc.altEn[i]) begin
        next_out[i] = pc.altVal[i];
        next_oe[i]  = 1'b0;
      end else begin
        next_out[i] = pc.latch[i];
        next_oe[i]  = ~(pc.dir[i] & pc.genEn);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc.pinOut <= '0;
      pc.pinOe  <= '1;
    end else begin
      pc.pinOut <= next_out;
      pc.pinOe  <= next_oe;
    end
  end
endmodule

/* File: verif/port_ab_monitor.sv */
// Assertions on the port A/B pin logic ports
`timescale 1ns/1ps
module port_ab_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [1:0] modePins,
  input wire logic       busCycle,
  input wire logic       busWrite,
  input wire logic [7:0] extAddrHigh,
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOe,
  input wire logic [7:0] portBPullEn,
  input wire logic [7:0] portEIn,
  input wire logic [1:0] portGHighIn,
  input wire logic [9:0] inputOnlyLevel,
  input wire logic       pulseAccumInput,
  input wire logic       captureFourIn,
  input wire logic [2:0] captureLowIn,
  input wire logic       rwPin
);
  logic [2:0] upCnt;
  logic       ready;
  logic       busMode;
  // Edges since reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upCnt <= 3'h0;
    end else if (upCnt != 3'h7) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  assign ready   = (upCnt == 3'h7);
  assign busMode = ready && modePins[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence pinsA4;
    $stable(portAIn)[*4];
  endsequence
  sequence pinsIn4;
    $stable({portGHighIn, portEIn})[*4];
  endsequence
  hiz_at_start_a: assert property (disable iff (1'b0)
    (rst || upCnt < 3'h4) |-> (portAOe & portBOe) == 8'hFF) else $error("pins driven at reset");
  rw_single_low_a: assert property (ready && !modePins[0] |-> !rwPin)
    else $error("rw pin not low in single chip");
  rw_read_high_a: assert property (busMode && !(busCycle && busWrite) |=> rwPin)
    else $error("rw pin not high for read");
  rw_write_low_a: assert property (busMode && busCycle && busWrite |=> !rwPin)
    else $error("rw pin not low for write");
  b_addr_bus_a: assert property (busMode |=> portBOe == 8'h00 && portBOut == $past(extAddrHigh))
    else $error("port B not carrying address");
  b_pull_off_a: assert property (busMode |=> portBPullEn == 8'h00)
    else $error("pull-ups on in bus mode");
  pull_input_a: assert property (ready |-> (portBPullEn & ~portBOe) == 8'h00)
    else $error("pull-up on driven pin");
  in_only_a: assert property (ready ##0 pinsIn4 |-> inputOnlyLevel == {portGHighIn, portEIn})
    else $error("input-only level wrong");
  timer_in_a: assert property (ready ##0 pinsA4 |->
    {pulseAccumInput, captureFourIn, captureLowIn} == {portAIn[7], portAIn[3], portAIn[2:0]})
    else $error("timer inputs wrong");
endmodule
bind port_a_b_io port_ab_monitor u_mon (.ref_clk, .rst, .modePins, .busCycle, .busWrite, .extAddrHigh,
  .portAIn, .portAOe, .portBOut, .portBOe, .portBPullEn, .portEIn, .portGHighIn, .inputOnlyLevel,
  .pulseAccumInput, .captureFourIn, .captureLowIn, .rwPin);

/* File: verif/pin_world.sv */
// External pin model for ports A and B
`timescale 1ns/1ps
module pin_world (
  input  wire logic [7:0] portAOut,
  input  wire logic [7:0] portAOe,
  input  wire logic [7:0] portBOut,
  input  wire logic [7:0] portBOe,
  input  wire logic [7:0] extA,
  input  wire logic [7:0] extB,
  output logic      [7:0] portAIn,
  output logic      [7:0] portBIn
);
  // Driven pins show the output, released ones the outside level
  always_comb begin
    portAIn = (portAOut & ~portAOe) | (extA & portAOe);
    portBIn = (portBOut & ~portBOe) | (extB & portBOe);
  end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the port A/B pin logic
`timescale 1ns/1ps
module tb;
  import port_ab_pkg::*;
  logic        ref_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, busCycle, busWrite, rwPin;
  logic [7:0]  wb_adr_i, extAddrHigh, timerPinLevel, portAIn, portAOut, portAOe, portEIn, extA, extB;
  logic [7:0]  portBIn, portBOut, portBOe, portBPullEn;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [1:0]  modePins, portGHighIn;
  logic [9:0]  inputOnlyLevel;
  logic [2:0]  captureLowIn;
  logic        pulseAccumInput, captureFourIn;
  int          err_total, samples_checked;

  port_a_b_io u_dut (.ref_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .modePins, .busCycle, .busWrite, .extAddrHigh, .timerPinLevel, .portAIn,
    .portAOut, .portAOe, .portBIn, .portBOut, .portBOe, .portBPullEn, .portEIn, .portGHighIn,
    .inputOnlyLevel, .pulseAccumInput, .captureFourIn, .captureLowIn, .rwPin);
  pin_world u_pins (.portAOut, .portAOe, .portBOut, .portBOe, .extA, .extB, .portAIn, .portBIn);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] sl,
                    output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_sel_i <= sl;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 40) begin
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 32'(d), 1'b1, 4'h1, q);
  endtask

  // Write with lane zero off, refused
  task automatic wr_nolane(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(a, 32'(d), 1'b1, 4'hE, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, '0, 1'b0, 4'h1, q);
    chk_reg(q, e);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    int         m, k;
    logic [7:0] da, db, tm, pu, la, lb, tp, eh, xa, xb, ev, ta, oa, ob, pa, pb;
    logic [1:0] gv;
    logic       bc, bw;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(86637));
    {wb_we_i, wb_cyc_i, wb_stb_i, busCycle, busWrite} = '0;
    {wb_adr_i, wb_dat_i, wb_sel_i, portGHighIn} = '0;
    {extAddrHigh, timerPinLevel, portEIn, extA, extB} = '0;
    for (m = 0; m < 4; m++) begin
      rst <= 1'b1;
      modePins <= m[1:0];
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rd(ADR_A_DIR, '0);
      rd(ADR_B_DIR, '0);
      chk_pin(portAOe, 8'hFF);
      chk_pin(portBOe, m[0] ? 8'h00 : 8'hFF);
      rd(ADR_STATUS, 32'(m) | 32'h0000_0004);
      da = 8'($urandom);
      db = 8'($urandom);
      tm = 8'($urandom);
      pu = 8'($urandom);
      wr(ADR_A_DIR, da);
      wr_nolane(ADR_A_DIR, ~da);
      rd(ADR_A_DIR, 32'(da));
      wr(ADR_B_DIR, db);
      wr(ADR_TIMER, tm);
      wr(ADR_PULLUP, pu);
      wr(ADR_IN_ONLY, 8'hFF);
      wr(8'h20, 8'hFF);
      rd(8'h20, '0);
      for (k = 0; k < 2; k++) begin
        {la, lb, tp, eh, xa, xb, ev} = 56'({$urandom, $urandom});
        {gv, bc, bw} = 4'($urandom);
        wr(ADR_A_DATA, la);
        wr(ADR_B_DATA, lb);
        timerPinLevel <= tp;
        extAddrHigh <= eh;
        extA <= xa;
        extB <= xb;
        portEIn <= ev;
        portGHighIn <= gv;
        busCycle <= bc;
        busWrite <= bw;
        repeat (6) @(posedge ref_clk);
        ta = tm & TIMER_OUT_OK;
        oa = ~(da | ta);
        ob = m[0] ? 8'h00 : ~db;
        pa = (((ta & tp) | (~ta & la)) & ~oa) | (xa & oa);
        pb = ((m[0] ? eh : lb) & ~ob) | (xb & ob);
        chk_pin(portAOe, oa);
        chk_pin(portAOut, (ta & tp) | (~ta & la));
        chk_pin(portBOe, ob);
        chk_pin(portBOut, m[0] ? eh : lb);
        chk_pin(portBPullEn, (!m[0] && pu[0]) ? ~db : 8'h00);
        chk_pin(8'(rwPin), 8'(m[0] && !(bc && bw)));
        rd(ADR_A_DATA, 32'(pa));
        rd(ADR_B_DATA, 32'(pb));
        rd(ADR_IN_ONLY, 32'({gv, ev}));
      end
    end
    tally_and_finish();
  end
endmodule
